//--- hdl/hcr_regs.svh
`ifndef HCR_REGS_SVH
`define HCR_REGS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define HCR_OFS_SCRATCH      8'h00
`define HCR_OFS_UNLOCK       8'h01
`define HCR_OFS_PIN_EXT      8'h05
`define HCR_OFS_IRQ_MASK     8'h07
`define HCR_OFS_SELF_TEST    8'h0A
`define HCR_OFS_MON_CTRL     8'h2F

// ****************************************************************
// Reset values and key
// ****************************************************************
`define HCR_RST_SCRATCH      8'h00
`define HCR_RST_PIN_EXT      8'h0F
`define HCR_RST_IRQ_MASK     7'h7F
`define HCR_RST_READ         8'h00
`define HCR_UNLOCK_KEY       8'h95

// ****************************************************************
// Field positions and widths
// ****************************************************************
`define HCR_PIN_NUM          4
`define HCR_PIN_VAL_LSB      4
`define HCR_SRC_NUM          7
`define HCR_SRC_MON          0
`define HCR_FAIL_NUM         5
`define HCR_RUN_BIT          5
`define HCR_MON_SNAP_BIT     6
`define HCR_MON_REQ_BIT      5
`define HCR_MON_CH_MSB       4

`endif

//--- hdl/hcr_pkg.sv
package hcr_pkg;

    // Host access as seen at the register port
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] data;
    } hcr_bus_t;

    // Slot monitor control fields
    typedef struct packed {
        logic       single;
        logic       request;
        logic [4:0] channel;
    } hcr_mon_ctl_t;

    // Slot monitor sequencing
    typedef enum logic [1:0] {
        MON_IDLE,
        MON_ARMED,
        MON_STREAM
    } hcr_mon_state_t;

endpackage : hcr_pkg

//--- hdl/hcr_pin_ext.sv
`timescale 1ns/100ps
`include "hcr_regs.svh"

module hcr_pin_ext (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Register access
    input  wire logic       wr_en,
    input  wire logic [7:0] wdata,
    output logic      [7:0] rdata,
    // Pins
    input  wire logic [3:0] pin_in,
    output logic      [3:0] pin_out,
    output logic      [3:0] pin_oe
);

    logic [7:0] reg_ff;
    logic [7:0] nxt_reg;
    logic [3:0] pin_ff;
    logic [3:0] oe_ff;
    logic [3:0] nxt_oe;

    // Next register value on host write
    always_comb begin
        nxt_reg = wr_en ? wdata : reg_ff;
        nxt_oe  = ~nxt_reg[`HCR_PIN_NUM-1:0];
    end

    // Register, pin sample and enable flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_ff <= `HCR_RST_PIN_EXT;
            pin_ff <= 4'h0;
            oe_ff  <= 4'h0;
        end else begin
            reg_ff <= nxt_reg;
            pin_ff <= pin_in;
            oe_ff  <= nxt_oe;
        end
    end

    // Per pin read value and drive
    genvar i;
    generate
        for (i = 0; i < `HCR_PIN_NUM; i = i + 1) begin : g_pin
            assign rdata[`HCR_PIN_VAL_LSB+i] = reg_ff[i] ? pin_ff[i] : reg_ff[`HCR_PIN_VAL_LSB+i];
            assign rdata[i]                  = reg_ff[i];
            assign pin_out[i]                = reg_ff[`HCR_PIN_VAL_LSB+i];
        end
    endgenerate

    assign pin_oe = oe_ff;

    // Enable follows direction bit
    pin_dir_a : assert property (@(posedge clk) disable iff (!rst_n)
        $past(wr_en) |-> pin_oe == ~$past(wdata[3:0]))
        else $error("pin enable does not follow direction");

endmodule : hcr_pin_ext

//--- hdl/hcr_slot_mon.sv
`timescale 1ns/100ps
`include "hcr_regs.svh"

module hcr_slot_mon (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    // Control write
    input  wire logic                 ctl_wr,
    input  hcr_pkg::hcr_mon_ctl_t     ctl,
    // Timeslot processing
    input  wire logic                 slot_strobe,
    input  wire logic [4:0]           slot_num,
    // Results
    output logic                      load,
    output logic                      poll_flag
);

    hcr_pkg::hcr_mon_state_t state_ff;
    hcr_pkg::hcr_mon_state_t nxt_state;
    logic [4:0]              chan_ff;
    logic [4:0]              nxt_chan;
    logic                    load_ff;
    logic                    nxt_load;
    logic                    poll_ff;
    logic                    nxt_poll;
    logic                    hit;

    // Sequencing of capture requests
    always_comb begin
        nxt_state = state_ff;
        nxt_chan  = chan_ff;
        nxt_poll  = poll_ff;
        hit       = slot_strobe && (slot_num == chan_ff);
        nxt_load  = hit && (state_ff != hcr_pkg::MON_IDLE);
        unique case (state_ff)
            hcr_pkg::MON_ARMED:  if (hit) nxt_state = hcr_pkg::MON_IDLE;
            hcr_pkg::MON_STREAM: ;
            hcr_pkg::MON_IDLE:   ;
        endcase
        if (ctl_wr) begin
            nxt_poll = 1'b0;
            nxt_chan = ctl.channel;
            if (ctl.request)
                nxt_state = ctl.single ? hcr_pkg::MON_ARMED : hcr_pkg::MON_STREAM;
            else if (state_ff == hcr_pkg::MON_STREAM)
                nxt_state = hcr_pkg::MON_IDLE;
        end
        if (nxt_load)
            nxt_poll = 1'b1;
    end

    // State flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= hcr_pkg::MON_IDLE;
            chan_ff  <= 5'h00;
            load_ff  <= 1'b0;
            poll_ff  <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            chan_ff  <= nxt_chan;
            load_ff  <= nxt_load;
            poll_ff  <= nxt_poll;
        end
    end

    assign load      = load_ff;
    assign poll_flag = poll_ff;

    // Single capture holds after one load
    single_hold_a : assert property (@(posedge clk) disable iff (!rst_n)
        (load && state_ff == hcr_pkg::MON_IDLE && !$past(ctl_wr)) ##1 !ctl_wr [*4] |-> !load)
        else $error("single capture loaded twice");

    // Load always raises the poll flag
    load_poll_a : assert property (@(posedge clk) disable iff (!rst_n)
        load |-> poll_flag)
        else $error("load without poll flag");

endmodule : hcr_slot_mon

//--- hdl/hcr_top.sv
`timescale 1ns/100ps
`include "hcr_regs.svh"

// How it works
// - Eight-bit scratch register, reset zero, write-protected, reads back last unlocked write, no side effects.
// - Direction bit one makes a pin input, zero output; reset leaves inputs.
// - Input pins read sampled level; output pins drive the written value bit.
// - Host writes run bit one; hardware holds it, clears it at test end.
// - Five read-only failure flags: central unit and filter units 0 to 3.
// - Write-only registers accept writes and read back as zero.
// - Five-bit channel field chooses the monitored timeslot.
// - While requested, capture selected slot then set monitor-ready in request and status.
// - Writing request zero clears poll flag; continuous mode also stops updating.
// - Single mode captures once per request write, interrupts, poll clears on new request.
// - Continuous mode refreshes every slot occurrence, interrupts only once.
// - Writing the key unlocks writes to protected registers.
// - Any other value relocks; reset starts locked.
// - Masked source shows in status, not in request; reset masks all seven.
// - Mask changes leave the source alone; unmasking an active source interrupts anew.
// - One mask bit per source, one suppresses; seven sources in fixed order.
module hcr_top (
    // Clock and reset
    input  wire logic                          CLK,
    input  wire logic                          RST_N,
    // Host register port
    input  wire logic                          WR,
    input  wire logic                          RD,
    input  wire logic [7:0]                    ADDR,
    input  wire logic [7:0]                    DIN,
    output logic      [7:0]                    DOUT,
    // Extension pins
    input  wire logic [3:0]                    PIN_IN,
    output logic      [3:0]                    PIN_OUT,
    output logic      [3:0]                    PIN_OE,
    // Memory self-test engine
    output logic                               SELF_TEST_START,
    input  wire logic                          SELF_TEST_DONE,
    input  wire logic [4:0]                    SELF_TEST_FAIL,
    // Timeslot monitor
    input  wire logic                          SLOT_STROBE,
    input  wire logic [4:0]                    SLOT_NUM,
    output logic                               MON_LOAD,
    output logic      [4:0]                    MON_CHANNEL,
    // Interrupt sources, status and request
    input  wire logic [6:1]                    SRC_ACTIVE,
    input  wire logic [6:0]                    IRQ_ACK,
    output logic      [6:0]                    STATUS,
    output logic      [6:0]                    IRQ_REQ,
    // Protection state
    output logic                               UNLOCKED
);

    // ****************************************************************
    // Host access decode
    // ****************************************************************
    hcr_pkg::hcr_bus_t     bus;
    hcr_pkg::hcr_mon_ctl_t mon_ctl;
    logic                  unlock_ff;
    logic                  nxt_unlock;

    assign bus     = '{wr: WR, rd: RD, addr: ADDR, data: DIN};
    assign mon_ctl = '{single:  DIN[`HCR_MON_SNAP_BIT],
                       request: DIN[`HCR_MON_REQ_BIT],
                       channel: DIN[`HCR_MON_CH_MSB:0]};

    // Write strobe for one offset
    function automatic logic hit_wr(input hcr_pkg::hcr_bus_t b, input logic [7:0] ofs);
        hit_wr = b.wr && (b.addr == ofs);
    endfunction : hit_wr

    logic wr_scratch;
    logic wr_unlock;
    logic wr_pin;
    logic wr_mask;
    logic wr_test;
    logic wr_mon;

    // Decoded strobes; protected registers need the unlock
    always_comb begin
        wr_scratch = hit_wr(bus, `HCR_OFS_SCRATCH) && unlock_ff;
        wr_unlock  = hit_wr(bus, `HCR_OFS_UNLOCK);
        wr_pin     = hit_wr(bus, `HCR_OFS_PIN_EXT);
        wr_mask    = hit_wr(bus, `HCR_OFS_IRQ_MASK);
        wr_test    = hit_wr(bus, `HCR_OFS_SELF_TEST) && unlock_ff;
        wr_mon     = hit_wr(bus, `HCR_OFS_MON_CTRL);
    end

    // ****************************************************************
    // Write protection
    // ****************************************************************
    always_comb begin
        nxt_unlock = unlock_ff;
        if (wr_unlock)
            nxt_unlock = (bus.data == `HCR_UNLOCK_KEY);
    end

    // ****************************************************************
    // Scratch and self-test registers
    // ****************************************************************
    logic [7:0] scratch_ff;
    logic [7:0] nxt_scratch;
    logic       run_ff;
    logic       nxt_run;
    logic       start_ff;
    logic       nxt_start;
    logic [4:0] fail_ff;
    logic [4:0] nxt_fail;

    // Run bit set by host, cleared by the engine
    always_comb begin
        nxt_scratch = wr_scratch ? bus.data : scratch_ff;
        nxt_run     = run_ff;
        nxt_fail    = fail_ff;
        nxt_start   = 1'b0;
        if (run_ff && SELF_TEST_DONE) begin
            nxt_run  = 1'b0;
            nxt_fail = SELF_TEST_FAIL;
        end else if (!run_ff && wr_test && bus.data[`HCR_RUN_BIT]) begin
            nxt_run   = 1'b1;
            nxt_start = 1'b1;
        end
    end

    // ****************************************************************
    // Interrupt mask, status and request
    // ****************************************************************
    logic [6:0] mask_ff;
    logic [6:0] nxt_mask;
    logic [6:0] status_ff;
    logic [6:0] nxt_status;
    logic [6:0] live_ff;
    logic [6:0] nxt_live;
    logic [6:0] req_ff;
    logic [6:0] nxt_req;
    logic       mon_poll;
    logic       mon_load;

    // Request bit set on a rising unmasked source; set beats ack
    always_comb begin
        nxt_mask   = wr_mask ? bus.data[`HCR_SRC_NUM-1:0] : mask_ff;
        nxt_status = {SRC_ACTIVE, mon_poll};
        nxt_live   = status_ff & ~mask_ff;
        nxt_req    = ((nxt_live & ~live_ff) | (req_ff & ~IRQ_ACK)) & ~mask_ff;
    end

    // ****************************************************************
    // Read path; write-only offsets answer zero
    // ****************************************************************
    logic [7:0] dout_ff;
    logic [7:0] nxt_dout;
    logic [7:0] pin_rdata;

    always_comb begin
        nxt_dout = dout_ff;
        if (bus.rd) begin
            unique case (bus.addr)
                `HCR_OFS_SCRATCH:   nxt_dout = scratch_ff;
                `HCR_OFS_PIN_EXT:   nxt_dout = pin_rdata;
                `HCR_OFS_SELF_TEST: nxt_dout = {2'b00, run_ff, fail_ff};
                default:            nxt_dout = `HCR_RST_READ;
            endcase
        end
    end

    // ****************************************************************
    // State flops
    // ****************************************************************
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            unlock_ff  <= 1'b0;
            scratch_ff <= `HCR_RST_SCRATCH;
            run_ff     <= 1'b0;
            start_ff   <= 1'b0;
            fail_ff    <= 5'h00;
            mask_ff    <= `HCR_RST_IRQ_MASK;
            status_ff  <= 7'h00;
            live_ff    <= 7'h00;
            req_ff     <= 7'h00;
            dout_ff    <= `HCR_RST_READ;
        end else begin
            unlock_ff  <= nxt_unlock;
            scratch_ff <= nxt_scratch;
            run_ff     <= nxt_run;
            start_ff   <= nxt_start;
            fail_ff    <= nxt_fail;
            mask_ff    <= nxt_mask;
            status_ff  <= nxt_status;
            live_ff    <= nxt_live;
            req_ff     <= nxt_req;
            dout_ff    <= nxt_dout;
        end
    end

    // ****************************************************************
    // Sub-blocks
    // ****************************************************************
    hcr_pin_ext u_pin (
        .clk     (CLK),
        .rst_n   (RST_N),
        .wr_en   (wr_pin),
        .wdata   (bus.data),
        .rdata   (pin_rdata),
        .pin_in  (PIN_IN),
        .pin_out (PIN_OUT),
        .pin_oe  (PIN_OE)
    );

    logic [4:0] chan_ff;
    logic [4:0] nxt_chan;

    assign nxt_chan = wr_mon ? mon_ctl.channel : chan_ff;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N)
            chan_ff <= 5'h00;
        else
            chan_ff <= nxt_chan;
    end

    hcr_slot_mon u_mon (
        .clk         (CLK),
        .rst_n       (RST_N),
        .ctl_wr      (wr_mon),
        .ctl         (mon_ctl),
        .slot_strobe (SLOT_STROBE),
        .slot_num    (SLOT_NUM),
        .load        (mon_load),
        .poll_flag   (mon_poll)
    );

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign DOUT            = dout_ff;
    assign SELF_TEST_START = start_ff;
    assign MON_LOAD        = mon_load;
    assign MON_CHANNEL     = chan_ff;
    assign STATUS          = status_ff;
    assign IRQ_REQ         = req_ff;
    assign UNLOCKED        = unlock_ff;

    // ****************************************************************
    // Checks
    // ****************************************************************
    scratch_readback_a : assert property (@(posedge CLK) disable iff (!RST_N)
        (wr_scratch ##1 !WR ##1 (RD && ADDR == `HCR_OFS_SCRATCH && !WR)) |=> DOUT == $past(DIN, 3))
        else $error("scratch readback mismatch");

    locked_write_a : assert property (@(posedge CLK) disable iff (!RST_N)
        (WR && ADDR == `HCR_OFS_SCRATCH && !unlock_ff) |=> $stable(scratch_ff))
        else $error("locked scratch changed");

    key_unlock_a : assert property (@(posedge CLK) disable iff (!RST_N)
        (WR && ADDR == `HCR_OFS_UNLOCK) |=> UNLOCKED == ($past(DIN) == `HCR_UNLOCK_KEY))
        else $error("unlock state wrong after key write");

    run_hold_a : assert property (@(posedge CLK) disable iff (!RST_N)
        (run_ff && !SELF_TEST_DONE) |=> run_ff)
        else $error("run bit dropped without done");

    run_clear_a : assert property (@(posedge CLK) disable iff (!RST_N)
        (run_ff && SELF_TEST_DONE) |=> !run_ff && fail_ff == $past(SELF_TEST_FAIL))
        else $error("run bit not cleared at done");

    masked_req_a : assert property (@(posedge CLK) disable iff (!RST_N)
        (mask_ff != 7'h00) |=> (IRQ_REQ & $past(mask_ff)) == 7'h00)
        else $error("masked source entered request");

    unmask_irq_a : assert property (@(posedge CLK) disable iff (!RST_N)
        ($fell(mask_ff[0]) && status_ff[0] && !live_ff[0]) |=> IRQ_REQ[0])
        else $error("unmask of active source gave no request");

    wo_read_a : assert property (@(posedge CLK) disable iff (!RST_N)
        (RD && (ADDR == `HCR_OFS_IRQ_MASK || ADDR == `HCR_OFS_MON_CTRL)) |=> DOUT == `HCR_RST_READ)
        else $error("write-only register read back");

    mon_ready_a : assert property (@(posedge CLK) disable iff (!RST_N)
        mon_load |=> STATUS[`HCR_SRC_MON])
        else $error("monitor capture did not show in status");

endmodule : hcr_top

//--- verification/hcr_bist_model.sv
`timescale 1ns/100ps

module hcr_bist_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Engine set-up from the bench
    input  wire logic [7:0] delay,
    input  wire logic [4:0] fail_val,
    // Engine handshake
    input  wire logic       start,
    output logic            done,
    output logic      [4:0] fail
);
    // ****************
    // Engine sequencing
    // ****************
    int cnt;

    // Runs a test after start; flags toggle outside done
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt  <= 0;
            done <= 1'b0;
            fail <= 5'h1F;
        end else begin
            done <= 1'b0;
            fail <= ~fail;
            if (start) cnt <= delay + 1;
            else if (cnt > 1) cnt <= cnt - 1;
            else if (cnt == 1) begin
                cnt  <= 0;
                done <= 1'b1;
                fail <= fail_val;
            end
        end
    end
endmodule : hcr_bist_model

//--- verification/tb_host_control_registers.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("[FAIL] %s exp %0h got %0h", n, e, g); end end

module tb_host_control_registers;
    // ****************
    // Signals
    // ****************
    logic       CLK = 1'b0, RST_N = 1'b0, WR = 1'b0, RD = 1'b0;
    logic [7:0] ADDR = 8'h00, DIN = 8'h00, DOUT, bdelay = 8'h0A;
    logic [3:0] PIN_IN = 4'h0, PIN_OUT, PIN_OE;
    logic       SELF_TEST_START, SELF_TEST_DONE, SLOT_STROBE = 1'b0, MON_LOAD, UNLOCKED;
    logic [4:0] SELF_TEST_FAIL, SLOT_NUM = 5'h00, MON_CHANNEL, bfail = 5'h00, ch, fl = 5'h00;
    logic [6:1] SRC_ACTIVE = 6'h00, src;
    logic [6:0] IRQ_ACK = 7'h00, STATUS, IRQ_REQ, m;
    logic [7:0] d;
    logic       lk = 1'b1, run = 1'b0;
    int         num_errors = 0, num_checks = 0, scr = 0, pio = 8'h0F, nst = 0, nld = 0, k;
    int         failq[$];

    hcr_top hcr_top_i (.CLK, .RST_N, .WR, .RD, .ADDR, .DIN, .DOUT, .PIN_IN, .PIN_OUT, .PIN_OE,
        .SELF_TEST_START, .SELF_TEST_DONE, .SELF_TEST_FAIL, .SLOT_STROBE, .SLOT_NUM, .MON_LOAD,
        .MON_CHANNEL, .SRC_ACTIVE, .IRQ_ACK, .STATUS, .IRQ_REQ, .UNLOCKED);
    hcr_bist_model hcr_bist_model_i (.clk(CLK), .rst_n(RST_N), .delay(bdelay), .fail_val(bfail),
        .start(SELF_TEST_START), .done(SELF_TEST_DONE), .fail(SELF_TEST_FAIL));

    // Clock and pulse counters
    always #12.5 CLK = ~CLK;
    always @(posedge CLK) begin
        if (SELF_TEST_START === 1'b1) nst++;
        if (MON_LOAD === 1'b1) nld++;
    end

    // ****************
    // Host tasks and model
    // ****************
    function automatic logic [7:0] exp_rd(input logic [7:0] a);
        logic [7:0] r;
        logic [7:0] p;
        r = 8'h00;
        p = 8'(pio);
        if (a == 8'h00) r = 8'(scr);
        if (a == 8'h0A) r = {2'h0, run, fl};
        if (a == 8'h05) begin
            r = p;
            for (int i = 0; i < 4; i++) if (p[i]) r[4+i] = PIN_IN[i];
        end
        return r;
    endfunction : exp_rd

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge CLK);
        WR = 1'b1;
        ADDR = a;
        DIN = v;
        @(negedge CLK);
        WR = 1'b0;
        if (a == 8'h00 && !lk) scr = v;
        if (a == 8'h01) lk = (v != 8'h95);
        if (a == 8'h05) pio = v;
    endtask : wr

    task automatic rd(input logic [7:0] a, input string n);
        @(negedge CLK);
        RD = 1'b1;
        ADDR = a;
        @(negedge CLK);
        RD = 1'b0;
        @(negedge CLK);
        `CHK(n, exp_rd(a), DOUT)
    endtask : rd

    task automatic strobe(input logic [4:0] n);
        @(negedge CLK);
        SLOT_STROBE = 1'b1;
        SLOT_NUM = n;
        @(negedge CLK);
        SLOT_STROBE = 1'b0;
        repeat (4) @(negedge CLK);
    endtask : strobe

    task automatic ack(input logic [6:0] v);
        @(negedge CLK);
        IRQ_ACK = v;
        @(negedge CLK);
        IRQ_ACK = 7'h00;
    endtask : ack

    task automatic conclude;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : conclude

    // Watchdog against a hang
    initial begin
        #1000000;
        num_errors++;
        conclude();
    end

    // ****************
    // Tests
    // ****************
    initial begin
        void'($urandom(32'h1e36));
        repeat (6) @(negedge CLK);
        RST_N = 1'b1;
        `CHK("oe", 4'h0, PIN_OE)
        `CHK("unlk", 1'b0, UNLOCKED)
        foreach (d[i]) rd(8'h00 + i, "rst");
        rd(8'h0A, "rst");
        rd(8'h2F, "rst");
        rd(8'h3C, "rst");
        wr(8'h00, 8'hA5);
        rd(8'h00, "lock");
        wr(8'h01, 8'h95);
        `CHK("unlk", 1'b1, UNLOCKED)
        repeat (6) begin
            wr(8'h00, 8'($urandom));
            rd(8'h00, "scr");
        end
        // Pin extension directions and levels
        repeat (8) begin
            d = 8'($urandom);
            PIN_IN = 4'($urandom);
            wr(8'h05, d);
            `CHK("oe", ~d[3:0], PIN_OE)
            `CHK("out", d[7:4] & ~d[3:0], PIN_OUT & ~d[3:0])
            repeat (2) @(negedge CLK);
            rd(8'h05, "pio");
        end
        wr(8'h01, 8'h96);
        `CHK("unlk", 1'b0, UNLOCKED)
        wr(8'h00, 8'h3C);
        rd(8'h00, "lock");
        k = nst;
        wr(8'h0A, 8'h20);
        repeat (2) @(negedge CLK);
        `CHK("lockst", k, nst)
        wr(8'h01, 8'h95);
        // Memory self-test runs
        repeat (3) begin
            bdelay = 8'(12 + $urandom % 20);
            bfail = 5'($urandom);
            failq.push_back(bfail);
            k = nst;
            wr(8'h0A, 8'h20);
            run = 1'b1;
            @(negedge CLK);
            `CHK("start", k + 1, nst)
            wr(8'h0A, 8'h20);
            rd(8'h0A, "run");
            `CHK("again", k + 1, nst)
            for (int n = 0; n < 100 && SELF_TEST_DONE !== 1'b1; n++) @(negedge CLK);
            run = 1'b0;
            fl = 5'(failq.pop_front());
            rd(8'h0A, "fail");
        end
        // Slot monitor, single then continuous; monitor source unmasked after capture
        ch = 5'($urandom);
        wr(8'h2F, {3'h3, ch});
        `CHK("ch", ch, MON_CHANNEL)
        k = nld;
        strobe(ch ^ 5'h01);
        `CHK("miss", k, nld)
        strobe(ch);
        `CHK("load", k + 1, nld)
        `CHK("poll", 1'b1, STATUS[0])
        `CHK("irqm", 1'b0, IRQ_REQ[0])
        wr(8'h07, 8'h7E);
        repeat (2) @(negedge CLK);
        `CHK("irq", 1'b1, IRQ_REQ[0])
        ack(7'h01);
        strobe(ch);
        `CHK("hold", k + 1, nld)
        `CHK("poll", 1'b1, STATUS[0])
        wr(8'h2F, {3'h1, ch});
        repeat (2) strobe(ch);
        `CHK("cont", k + 3, nld)
        ack(7'h01);
        strobe(ch);
        `CHK("cont", k + 4, nld)
        `CHK("once", 1'b0, IRQ_REQ[0])
        wr(8'h2F, {3'h0, ch});
        repeat (3) @(negedge CLK);
        `CHK("clr", 1'b0, STATUS[0])
        strobe(ch);
        `CHK("stop", k + 4, nld)
        // Mask and unmask of active sources
        repeat (4) begin
            wr(8'h07, 8'h7F);
            ack(7'h7F);
            src = 6'($urandom) | 6'h01;
            SRC_ACTIVE = src;
            repeat (3) @(negedge CLK);
            `CHK("stat", src, STATUS[6:1])
            `CHK("req", 7'h00, IRQ_REQ)
            m = 7'($urandom) | 7'h01;
            wr(8'h07, {1'b0, m});
            repeat (3) @(negedge CLK);
            `CHK("req", src & ~m[6:1], IRQ_REQ[6:1])
            `CHK("stat", src, STATUS[6:1])
        end
        conclude();
    end
endmodule : tb_host_control_registers
